/* File: hw/pmq_regs.sv */
// AXI4-Lite register set for quality snapshots and MMD capability words
`timescale 1ns/1ps
`include "pmq_consts.svh"

module pmq_regs #(
   parameter int ADDR_W = 12
) (
   input  wire logic                  i_core_clk,
   input  wire logic                  i_sys_rst,
   // Live quality measurements (same clock domain)
   input  wire pmq_pkg::pmq_meas_t    i_meas,
   input  wire logic                  i_partner_eee_100tx,
   // AXI4-Lite slave
   input  wire logic [ADDR_W-1:0]     i_awaddr,
   input  wire logic                  i_awvalid,
   output logic                       o_awready,
   input  wire logic [31:0]           i_wdata,
   input  wire logic [3:0]            i_wstrb,
   input  wire logic                  i_wvalid,
   output logic                       o_wready,
   output logic [1:0]                 o_bresp,
   output logic                       o_bvalid,
   input  wire logic                  i_bready,
   input  wire logic [ADDR_W-1:0]     i_araddr,
   input  wire logic                  i_arvalid,
   output logic                       o_arready,
   output logic [31:0]                o_rdata,
   output logic [1:0]                 o_rresp,
   output logic                       o_rvalid,
   input  wire logic                  i_rready,
   // Block state
   output logic                       o_eee_adv_100tx,
   output logic                       o_capture_pulse
);

   // Decode slices address bits 11:2, so a narrower bus cannot be served
   if (ADDR_W < 12 || ADDR_W > 32)
   begin : g_bad_addr_w
      $error("pmq_regs: ADDR_W must be 12..32");
   end

   // Write and read channel state
   logic                    aw_held_q;
   logic [ADDR_W-1:0]       aw_addr_q;
   logic                    w_held_q;
   logic [31:0]             w_data_q;
   logic [3:0]              w_strb_q;
   pmq_pkg::pmq_bus_state_t wr_state_q;
   pmq_pkg::pmq_bus_state_t rd_state_q;
   logic                    wr_do;
   logic [9:0]              wr_idx;
   logic [9:0]              rd_idx;
   logic                    wr_hit;
   logic                    rd_hit;
   logic [15:0]             rd_word;

   // Snapshot state; worst-case trackers sit in one instance per field other than mean error
   logic                    eee_adv_q;
   logic                    capture_q;
   logic [15:0]             snap_mean_q;
   logic [8:0]              snap_mse;
   logic [8:0]              snap_mse_wc;
   logic [2:0]              snap_sqi;
   logic [2:0]              snap_sqi_wc;
   logic [7:0]              snap_peak;
   logic [7:0]              snap_peak_wc;

   // Read words with reserved bits tied low
   logic [15:0]             word_eee_local;
   logic [15:0]             word_eee_partner;
   logic [15:0]             word_mse_cur;
   logic [15:0]             word_mse_worst;
   logic [15:0]             word_sqi;
   logic [15:0]             word_peak;

   // Write fires once both address and data are in hand
   assign wr_do  = aw_held_q && w_held_q && (wr_state_q == pmq_pkg::PMQ_IDLE);
   assign wr_idx = aw_addr_q[11:2];
   assign rd_idx = i_araddr[11:2];
   // Upper address bits must be zero and word aligned
   assign wr_hit = (aw_addr_q[1:0] == 2'b00) && ((aw_addr_q >> 12) == '0);
   assign rd_hit = (i_araddr[1:0] == 2'b00) && ((i_araddr >> 12) == '0);

   // Address and data capture in either order
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         aw_held_q <= 1'b0;
         w_held_q  <= 1'b0;
         aw_addr_q <= '0;
         w_data_q  <= 32'h0000_0000;
         w_strb_q  <= 4'h0;
         o_awready <= 1'b0;
         o_wready  <= 1'b0;
      end
      else
      begin
         o_awready <= !aw_held_q && !(i_awvalid && o_awready) && (wr_state_q == pmq_pkg::PMQ_IDLE);
         o_wready  <= !w_held_q && !(i_wvalid && o_wready) && (wr_state_q == pmq_pkg::PMQ_IDLE);
         if (i_awvalid && o_awready)
         begin
            aw_held_q <= 1'b1;
            aw_addr_q <= i_awaddr;
         end
         else if (wr_do)
            aw_held_q <= 1'b0;
         if (i_wvalid && o_wready)
         begin
            w_held_q <= 1'b1;
            w_data_q <= i_wdata;
            w_strb_q <= i_wstrb;
         end
         else if (wr_do)
            w_held_q <= 1'b0;
      end
   end

   // Write response; misaligned addresses or set bits above bit 11 answer SLVERR
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         wr_state_q <= pmq_pkg::PMQ_IDLE;
         o_bvalid   <= 1'b0;
         o_bresp    <= `PMQ_RESP_OKAY;
      end
      else
      begin
         case (wr_state_q)
            pmq_pkg::PMQ_IDLE:
            begin
               if (wr_do)
               begin
                  wr_state_q <= pmq_pkg::PMQ_RESP;
                  o_bvalid   <= 1'b1;
                  o_bresp    <= wr_hit ? `PMQ_RESP_OKAY : `PMQ_RESP_SLVERR;
               end
            end
            pmq_pkg::PMQ_RESP:
            begin
               if (i_bready)
               begin
                  wr_state_q <= pmq_pkg::PMQ_IDLE;
                  o_bvalid   <= 1'b0;
               end
            end
            default:
               wr_state_q <= pmq_pkg::PMQ_IDLE;
         endcase
      end
   end

   // Writable bits: EEE advert and capture trigger; all else ignores writes
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         eee_adv_q <= 1'b0;
         capture_q <= 1'b0;
      end
      else
      begin
         capture_q <= 1'b0;
         if (wr_do && wr_hit)
         begin
            if (wr_idx == `PMQ_IDX_EEE_LOCAL)
            begin
               if (w_strb_q[0])
                  eee_adv_q <= w_data_q[`PMQ_EEE_100TX_BIT];
            end
            else if (wr_idx == `PMQ_IDX_QCTL)
            begin
               if (w_strb_q[1])
                  capture_q <= w_data_q[`PMQ_CAPTURE_BIT];
            end
         end
      end
   end

   // Mean error has no worst case; it only follows the capture pulse
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
         snap_mean_q <= `PMQ_ZERO16;
      else if (capture_q)
         snap_mean_q <= i_meas.mean_err;
   end

   // Mean square error: a larger value is worse
   pmq_worst_trk #(
      .WIDTH     (9),
      .LOW_WORST (1'b0)
   ) u_trk_mse (
      .i_core_clk   (i_core_clk),
      .i_sys_rst    (i_sys_rst),
      .i_capture    (capture_q),
      .i_live       (i_meas.mse),
      .o_cur_snap   (snap_mse),
      .o_worst_snap (snap_mse_wc)
   );

   // Quality index: the lowest index is the worst link
   pmq_worst_trk #(
      .WIDTH     (3),
      .LOW_WORST (1'b1)
   ) u_trk_sqi (
      .i_core_clk   (i_core_clk),
      .i_sys_rst    (i_sys_rst),
      .i_capture    (capture_q),
      .i_live       (i_meas.sqi),
      .o_cur_snap   (snap_sqi),
      .o_worst_snap (snap_sqi_wc)
   );

   // Peak error: invalid and not-ready codes rank above any valid peak
   pmq_worst_trk #(
      .WIDTH     (8),
      .LOW_WORST (1'b0)
   ) u_trk_peak (
      .i_core_clk   (i_core_clk),
      .i_sys_rst    (i_sys_rst),
      .i_capture    (capture_q),
      .i_live       (i_meas.peak),
      .o_cur_snap   (snap_peak),
      .o_worst_snap (snap_peak_wc)
   );

   // Reserved bits stay low whatever was written
   assign word_eee_local   = {14'h0000, eee_adv_q, 1'b0};
   assign word_eee_partner = {14'h0000, i_partner_eee_100tx, 1'b0};
   assign word_mse_cur     = {7'h00, snap_mse};
   assign word_mse_worst   = {7'h00, snap_mse_wc};
   assign word_sqi         = {8'h00, snap_sqi_wc, 1'b0, snap_sqi, 1'b0};
   assign word_peak        = {snap_peak_wc, snap_peak};

   // Read word mux; reserved bits held at zero
   always_comb
   begin
      rd_word = `PMQ_ZERO16;
      if (rd_idx == `PMQ_IDX_AN_PRESENT_LO || rd_idx == `PMQ_IDX_VEND_PRESENT_LO)
         rd_word = `PMQ_PRESENT_LO_VAL;
      else if (rd_idx == `PMQ_IDX_AN_PRESENT_HI || rd_idx == `PMQ_IDX_VEND_PRESENT_HI)
         rd_word = `PMQ_PRESENT_HI_VAL;
      else if (rd_idx == `PMQ_IDX_EEE_LOCAL)
         rd_word = word_eee_local;
      else if (rd_idx == `PMQ_IDX_EEE_PARTNER)
         rd_word = word_eee_partner;
      else if (rd_idx == `PMQ_IDX_VEND_STATUS)
         rd_word = `PMQ_VEND_STATUS_VAL;
      else if (rd_idx == `PMQ_IDX_VEND_ID_ONE || rd_idx == `PMQ_IDX_VEND_ID_TWO
               || rd_idx == `PMQ_IDX_VEND_PKG_ONE || rd_idx == `PMQ_IDX_VEND_PKG_TWO)
         rd_word = `PMQ_ZERO16;
      else if (rd_idx == `PMQ_IDX_MEAN_ERR)
         rd_word = snap_mean_q;
      else if (rd_idx == `PMQ_IDX_MSE_CUR)
         rd_word = word_mse_cur;
      else if (rd_idx == `PMQ_IDX_MSE_WORST)
         rd_word = word_mse_worst;
      else if (rd_idx == `PMQ_IDX_SQI)
         rd_word = word_sqi;
      else if (rd_idx == `PMQ_IDX_PEAK)
         rd_word = word_peak;
      else if (rd_idx == `PMQ_IDX_QCTL)
         rd_word = `PMQ_ZERO16;
   end

   // Read channel; one cycle from address accept to data
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         rd_state_q <= pmq_pkg::PMQ_IDLE;
         o_arready  <= 1'b0;
         o_rvalid   <= 1'b0;
         o_rdata    <= 32'h0000_0000;
         o_rresp    <= `PMQ_RESP_OKAY;
      end
      else
      begin
         case (rd_state_q)
            pmq_pkg::PMQ_IDLE:
            begin
               o_arready <= !(i_arvalid && o_arready);
               if (i_arvalid && o_arready)
               begin
                  rd_state_q <= pmq_pkg::PMQ_RESP;
                  o_rvalid   <= 1'b1;
                  o_rdata    <= {16'h0000, rd_hit ? rd_word : `PMQ_ZERO16};
                  o_rresp    <= rd_hit ? `PMQ_RESP_OKAY : `PMQ_RESP_SLVERR;
               end
            end
            pmq_pkg::PMQ_RESP:
            begin
               o_arready <= 1'b0;
               if (i_rready)
               begin
                  rd_state_q <= pmq_pkg::PMQ_IDLE;
                  o_rvalid   <= 1'b0;
                  o_arready  <= 1'b1;
               end
            end
            default:
               rd_state_q <= pmq_pkg::PMQ_IDLE;
         endcase
      end
   end

   // Block-facing state outputs, straight from flops
   assign o_eee_adv_100tx = eee_adv_q;
   assign o_capture_pulse = capture_q;

endmodule // pmq_regs

// One quality field: running worst case plus its capture snapshots
module pmq_worst_trk #(
   parameter int WIDTH     = 9,
   parameter bit LOW_WORST = 1'b0
) (
   input  wire logic             i_core_clk,
   input  wire logic             i_sys_rst,
   input  wire logic             i_capture,
   input  wire logic [WIDTH-1:0] i_live,
   output logic      [WIDTH-1:0] o_cur_snap,
   output logic      [WIDTH-1:0] o_worst_snap
);

   // Fields wider than a register word cannot be shown
   if (WIDTH < 1 || WIDTH > 16)
   begin : g_bad_width
      $error("pmq_worst_trk: WIDTH must be 1..16");
   end

   // Running worst of the open interval
   logic [WIDTH-1:0] trk_q;
   logic             trk_valid_q;
   logic             live_worse;

   // Direction of worse is fixed per field at elaboration
   assign live_worse = LOW_WORST ? (i_live < trk_q) : (i_live > trk_q);

   // Seeds from live after reset so a stale zero never counts as worst
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         trk_q       <= '0;
         trk_valid_q <= 1'b0;
      end
      else if (i_capture || !trk_valid_q)
      begin
         trk_q       <= i_live;
         trk_valid_q <= 1'b1;
      end
      else if (live_worse)
         trk_q <= i_live;
   end

   // Snapshots; the capture cycle's own value counts toward the worst
   always_ff @(posedge i_core_clk)
   begin
      if (i_sys_rst)
      begin
         o_cur_snap   <= '0;
         o_worst_snap <= '0;
      end
      else if (i_capture)
      begin
         o_cur_snap   <= i_live;
         o_worst_snap <= live_worse ? i_live : trk_q;
      end
   end

endmodule // pmq_worst_trk

/* File: pkg/pmq_consts.svh */
// Register offsets, field positions and reset values of the quality register set
// How it works
// - Devices-present-1 words read bits 7 and 3 set
// - Devices-present-2 words read only bit 14 set
// - Local EEE bit 1 writable, resets zero
// - Partner EEE bit 1 reported, bits 6:2 zero
// - Vendor device and package identifiers read zero
// - Vendor status presence field reads binary 10
// - Mean slicer error snapshot, 16 bits, resets zero
// - Current MSE snapshot in bits 8:0
// - Worst MSE since previous capture in bits 8:0
// - Worst quality index 7:5, current 3:1
// - Current peak error in bits 7:0
// - Worst peak error in bits 15:8
// - Snapshots refresh only on capture write
// - Capture bit 15 triggers then self-clears
`ifndef PMQ_CONSTS_SVH
`define PMQ_CONSTS_SVH

// Register index (MMD.register); byte address is four times the index
`define PMQ_IDX_AN_PRESENT_LO     10'd5
`define PMQ_IDX_AN_PRESENT_HI     10'd6
`define PMQ_IDX_EEE_LOCAL         10'd60
`define PMQ_IDX_EEE_PARTNER       10'd61
`define PMQ_IDX_VEND_ID_ONE       10'd130
`define PMQ_IDX_VEND_ID_TWO       10'd131
`define PMQ_IDX_VEND_PRESENT_LO   10'd133
`define PMQ_IDX_VEND_PRESENT_HI   10'd134
`define PMQ_IDX_VEND_STATUS       10'd136
`define PMQ_IDX_VEND_PKG_ONE      10'd142
`define PMQ_IDX_VEND_PKG_TWO      10'd143
`define PMQ_IDX_MEAN_ERR          10'd144
`define PMQ_IDX_MSE_CUR           10'd145
`define PMQ_IDX_MSE_WORST         10'd146
`define PMQ_IDX_SQI               10'd147
`define PMQ_IDX_PEAK              10'd148
`define PMQ_IDX_QCTL              10'd149

// Fixed read values
`define PMQ_PRESENT_LO_VAL        16'h0088
`define PMQ_PRESENT_HI_VAL        16'h4000
`define PMQ_VEND_STATUS_VAL       16'h8000
`define PMQ_ZERO16                16'h0000

// Field positions
`define PMQ_EEE_100TX_BIT         1
`define PMQ_CAPTURE_BIT           15

// AXI responses
`define PMQ_RESP_OKAY             2'b00
`define PMQ_RESP_SLVERR           2'b10

`endif

/* File: pkg/pmq_pkg.sv */
// Types of the quality register set
package pmq_pkg;

   // Live measurements from the quality engine
   typedef struct packed {
      logic [15:0] mean_err;
      logic [8:0]  mse;
      logic [2:0]  sqi;
      logic [7:0]  peak;
   } pmq_meas_t;

   // Bus slave states
   typedef enum logic [1:0] {
      PMQ_IDLE,
      PMQ_RESP
   } pmq_bus_state_t;

endpackage

/* File: sim/pmq_regs_monitor.sv */
// Bus and snapshot checks for the quality register set
`timescale 1ns/1ps
`include "pmq_consts.svh"
module pmq_regs_monitor #(
   parameter int ADDR_W = 12
) (
   input  wire logic              i_core_clk,
   input  wire logic              i_sys_rst,
   input  wire logic [ADDR_W-1:0] i_awaddr,
   input  wire logic              i_awvalid,
   input  wire logic              o_awready,
   input  wire logic [31:0]       i_wdata,
   input  wire logic [3:0]        i_wstrb,
   input  wire logic              i_wvalid,
   input  wire logic              o_wready,
   input  wire logic              o_bvalid,
   input  wire logic              i_bready,
   input  wire logic              i_arvalid,
   input  wire logic              o_arready,
   input  wire logic [31:0]       o_rdata,
   input  wire logic              o_rvalid,
   input  wire logic              i_rready,
   input  wire logic              o_eee_adv_100tx,
   input  wire logic              o_capture_pulse
);
   localparam logic [11:0] QCTL_B = {`PMQ_IDX_QCTL, 2'b00};
   localparam logic [11:0] EEE_B  = {`PMQ_IDX_EEE_LOCAL, 2'b00};
   logic wr_both;

   default clocking @(posedge i_core_clk); endclocking
   default disable iff (i_sys_rst);

   // Both write halves taken at one edge; the bench always offers them together
   assign wr_both = i_awvalid && o_awready && i_wvalid && o_wready;

   a_bresp_stands: assert property (o_bvalid && !i_bready |=> o_bvalid)
      else $error("write response dropped early");
   a_rdata_stands: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
      else $error("read data not held");
   a_upper_zero: assert property (o_rvalid |-> o_rdata[31:16] == 16'h0000)
      else $error("upper read half not zero");
   a_read_answer: assert property (i_arvalid && o_arready |=> o_rvalid)
      else $error("read answer late");
   a_write_answer: assert property (wr_both |-> ##[1:3] o_bvalid)
      else $error("write answer late");
   a_pulse_single: assert property (o_capture_pulse |=> !o_capture_pulse)
      else $error("capture pulse too long");
   a_pulse_on_write: assert property (o_capture_pulse |-> $rose(o_bvalid))
      else $error("capture without a write");
   a_capture_fires: assert property (wr_both && i_awaddr == ADDR_W'(QCTL_B) && i_wdata[15]
      && i_wstrb[1] |-> ##[1:3] o_capture_pulse)
      else $error("capture write gave no pulse");
   a_eee_sets: assert property (wr_both && i_awaddr == ADDR_W'(EEE_B) && i_wdata[1]
      && i_wstrb[0] |-> ##[1:3] o_eee_adv_100tx)
      else $error("advert bit not set");

   c_capture: cover property (o_capture_pulse);
   c_read: cover property (o_rvalid && i_rready);
   c_eee: cover property (o_eee_adv_100tx);
endmodule // pmq_regs_monitor

bind pmq_regs pmq_regs_monitor #(.ADDR_W(ADDR_W)) u_mon (.*);

/* File: sim/tb.sv */
// Bus-level testbench for the quality register set
`timescale 1ns/1ps
`include "pmq_consts.svh"
module tb;
   logic               clk, rst, lp_eee, eee, cap;
   pmq_pkg::pmq_meas_t meas;
   logic [11:0]        awaddr, araddr;
   logic [31:0]        wdata, rdata, rd;
   logic [3:0]         wstrb;
   logic [1:0]         bresp, rresp, resp;
   logic               awvalid, awready, wvalid, wready, bvalid, bready;
   logic               arvalid, arready, rvalid, rready;
   int                 err_total, n_compared;

   pmq_regs uut (
      .i_core_clk(clk), .i_sys_rst(rst), .i_meas(meas), .i_partner_eee_100tx(lp_eee),
      .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready), .i_wdata(wdata),
      .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready), .o_bresp(bresp),
      .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr), .i_arvalid(arvalid),
      .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp), .o_rvalid(rvalid),
      .i_rready(rready), .o_eee_adv_100tx(eee), .o_capture_pulse(cap)
   );

   initial
   begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Compare and count
   task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
      n_compared++;
      if (s !== e)
      begin
         err_total++;
         $display("BAD %s exp %h saw %h", nm, e, s);
      end
   endtask

   task automatic close_out;
      $display("compared %0d bad %0d", n_compared, err_total);
      if (err_total == 0 && n_compared > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   // A wait that ran out ends the run
   task automatic lim(input logic ok);
      if (!ok)
      begin
         chk("bus_wait", 32'h0, 32'h1);
         close_out();
      end
   endtask

   // One write; each channel dropped at the edge it is taken
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic ah, wh, bh;
      int   n;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      bh = 1'b0;
      for (n = 0; n < 40 && !bh; n++)
      begin
         @(negedge clk);
         ah = awvalid & awready;
         wh = wvalid & wready;
         bh = bvalid;
         resp = bresp;
         @(posedge clk);
         if (ah) awvalid <= 1'b0;
         if (wh) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      lim(bh);
   endtask

   // One read; data taken at the edge rvalid is seen
   task automatic rdw(input logic [11:0] a);
      logic ah, rh;
      int   n;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      rh = 1'b0;
      for (n = 0; n < 40 && !rh; n++)
      begin
         @(negedge clk);
         ah = arvalid & arready;
         rh = rvalid;
         rd = rdata;
         resp = rresp;
         @(posedge clk);
         if (ah) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      lim(rh);
   endtask

   // Read a register by index and expect an OKAY word
   task automatic rdc(input logic [9:0] ix, input logic [31:0] e, input string nm);
      rdw({ix, 2'b00});
      chk(nm, rd, e);
      chk("rresp", {30'h0, resp}, 32'h0);
   endtask

   initial
   begin
      err_total = 0;
      n_compared = 0;
      rst = 1'b1;
      lp_eee = 1'b1;
      meas = '{16'h1234, 9'h0a5, 3'h6, 8'h0a};
      {awaddr, araddr, wdata, wstrb} = '0;
      {awvalid, wvalid, bready, arvalid, rready} = '0;
      wstrb = 4'hf;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      rdc(`PMQ_IDX_AN_PRESENT_LO, 32'h0000_0088, "an_lo");
      rdc(`PMQ_IDX_VEND_PRESENT_LO, 32'h0000_0088, "vd_lo");
      rdc(`PMQ_IDX_AN_PRESENT_HI, 32'h0000_4000, "an_hi");
      rdc(`PMQ_IDX_VEND_PRESENT_HI, 32'h0000_4000, "vd_hi");
      rdc(`PMQ_IDX_VEND_STATUS, 32'h0000_8000, "vd_st");
      rdc(`PMQ_IDX_VEND_ID_ONE, 32'h0, "id1");
      rdc(`PMQ_IDX_VEND_ID_TWO, 32'h0, "id2");
      rdc(`PMQ_IDX_VEND_PKG_ONE, 32'h0, "pk1");
      rdc(`PMQ_IDX_VEND_PKG_TWO, 32'h0, "pk2");
      rdc(`PMQ_IDX_EEE_LOCAL, 32'h0, "eee");
      rdc(`PMQ_IDX_EEE_PARTNER, 32'h0000_0002, "lp_on");
      rdc(`PMQ_IDX_MEAN_ERR, 32'h0, "mean");
      rdc(`PMQ_IDX_MSE_CUR, 32'h0, "mse");
      rdc(`PMQ_IDX_SQI, 32'h0, "sqi");
      rdc(`PMQ_IDX_PEAK, 32'h0, "peak");
      lp_eee <= 1'b0;
      rdc(`PMQ_IDX_EEE_PARTNER, 32'h0, "lp_off");
      $display("test reset values done");
      // Advert bit, refused and ignored writes
      wr({`PMQ_IDX_EEE_LOCAL, 2'b00}, 32'hffff_ffff);
      rdc(`PMQ_IDX_EEE_LOCAL, 32'h0000_0002, "eee_set");
      chk("eee_pin", {31'h0, eee}, 32'h1);
      wr(12'h0f2, 32'h0);
      chk("bresp_bad", {30'h0, resp}, 32'h2);
      rdc(`PMQ_IDX_EEE_LOCAL, 32'h0000_0002, "eee_kept");
      rdw(12'h0f2);
      chk("rresp_bad", {30'h0, resp}, 32'h2);
      wr({`PMQ_IDX_EEE_LOCAL, 2'b00}, 32'h0);
      chk("eee_pin0", {31'h0, eee}, 32'h0);
      wr({`PMQ_IDX_VEND_STATUS, 2'b00}, 32'hffff_ffff);
      chk("bresp_ro", {30'h0, resp}, 32'h0);
      rdc(`PMQ_IDX_VEND_STATUS, 32'h0000_8000, "st_kept");
      wr({`PMQ_IDX_MEAN_ERR, 2'b00}, 32'hffff_ffff);
      rdc(`PMQ_IDX_MEAN_ERR, 32'h0, "mean_ro");
      $display("test access done");
      // First capture: current fields only, worst depends on history
      wr({`PMQ_IDX_QCTL, 2'b00}, 32'h0000_8000);
      rdc(`PMQ_IDX_QCTL, 32'h0, "qctl_sc");
      rdc(`PMQ_IDX_MEAN_ERR, 32'h0000_1234, "mean1");
      rdc(`PMQ_IDX_MSE_CUR, 32'h0000_00a5, "mse1");
      rdw({`PMQ_IDX_SQI, 2'b00});
      chk("sqi1", {29'h0, rd[3:1]}, 32'h6);
      rdw({`PMQ_IDX_PEAK, 2'b00});
      chk("peak1", {24'h0, rd[7:0]}, 32'h0a);
      // Interval with a bad patch, then settling before capture
      meas <= '{16'h5678, 9'h1ff, 3'h2, 8'hc8};
      repeat (4) @(posedge clk);
      meas <= '{16'h0abc, 9'h003, 3'h4, 8'h1e};
      rdc(`PMQ_IDX_MEAN_ERR, 32'h0000_1234, "mean_held");
      wr({`PMQ_IDX_QCTL, 2'b00}, 32'h0000_8000);
      rdc(`PMQ_IDX_MEAN_ERR, 32'h0000_0abc, "mean2");
      rdc(`PMQ_IDX_MSE_CUR, 32'h0000_0003, "mse2");
      rdc(`PMQ_IDX_MSE_WORST, 32'h0000_01ff, "msew2");
      rdc(`PMQ_IDX_SQI, 32'h0000_0048, "sqi2");
      rdc(`PMQ_IDX_PEAK, 32'h0000_c81e, "peak2");
      // Steady input: worst restarts and equals current
      wr({`PMQ_IDX_QCTL, 2'b00}, 32'h0000_8000);
      rdc(`PMQ_IDX_MSE_WORST, 32'h0000_0003, "msew3");
      rdc(`PMQ_IDX_SQI, 32'h0000_0088, "sqi3");
      rdc(`PMQ_IDX_PEAK, 32'h0000_1e1e, "peak3");
      $display("test capture done");
      // Mid-run reset clears the advert bit and the worst MSE and peak snapshots
      wr({`PMQ_IDX_EEE_LOCAL, 2'b00}, 32'h0000_0002);
      chk("eee_pin1", {31'h0, eee}, 32'h1);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      chk("eee_rst", {31'h0, eee}, 32'h0);
      rdc(`PMQ_IDX_EEE_LOCAL, 32'h0, "eee_rst_rd");
      rdc(`PMQ_IDX_MSE_WORST, 32'h0, "msew_rst");
      rdc(`PMQ_IDX_PEAK, 32'h0, "peak_rst");
      $display("test mid-run reset done");
      close_out();
   end
endmodule // tb
